// ==== design/twm_pkg.sv ====
// Purpose: shared constants for the two-wire serial master
// Assumes: command side on clk (10 MHz), bit engine on link_clk (30 ns)
// Notes: constants only, no logic
package twm_pkg;

    // rates of the two clocks
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned LINK_CLK_NS = 30;
    localparam int unsigned LINK_HZ = 1_000_000_000 / LINK_CLK_NS;

    // serial clock targets, as kHz figures
    localparam int unsigned FAST_SCL_KHZ = 400;
    localparam int unsigned STD_SCL_KHZ = 100;

    // quarter-bit counts in link clocks, rounded up so scl never runs fast
    localparam int unsigned FAST_QTR_CYC =
        (LINK_HZ + 4 * FAST_SCL_KHZ * 1000 - 1) / (4 * FAST_SCL_KHZ * 1000);
    localparam int unsigned STD_QTR_CYC =
        (LINK_HZ + 4 * STD_SCL_KHZ * 1000 - 1) / (4 * STD_SCL_KHZ * 1000);
    localparam int unsigned QTR_W = 8;

    // default data capacity of one transfer leg, in bytes
    localparam int unsigned MAX_BYTES = 4;

    // slave address width and bit index of the acknowledge slot
    localparam int unsigned ADDR_W = 7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    // transfer types
    typedef enum logic [1:0] {
        TWM_RD = 2'h0,
        TWM_WR = 2'h1,
        TWM_RD_WR = 2'h2,
        TWM_WR_RD = 2'h3
    } twm_xfer_type;

    // bit engine states, one-hot
    typedef enum logic [6:0] {
        TWM_IDLE = 7'h01,
        TWM_START = 7'h02,
        TWM_ADDR = 7'h04,
        TWM_WDATA = 7'h08,
        TWM_RDATA = 7'h10,
        TWM_RSTART = 7'h20,
        TWM_STOP = 7'h40
    } twm_state_type;

endpackage

// ==== design/twm_sync.sv ====
// Purpose: two-flop synchroniser for levels and toggles
// Assumes: input comes from another clock domain or a pin
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
module twm_sync #(
    parameter int unsigned W = 1
) (
    // destination clock and synchronous reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous input and synchronised output
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // two stages on the destination clock
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule

// ==== design/twm_master.sv ====
// Purpose: two-wire serial master for configuration memories
// Assumes: command fields valid with cmd_start; one master on the bus
// Notes: scl is driven only; no stretching is looked at
`timescale 1ns/1ns
module twm_master #(
    parameter int unsigned NBYTES = twm_pkg::MAX_BYTES
) (
    // command side clock and reset
    input wire logic clk,
    input wire logic rst,
    // command port from the processor
    input wire logic cmd_start,
    input wire twm_pkg::twm_xfer_type cmd_type,
    input wire logic [twm_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic cmd_fast,
    input wire logic [$clog2(NBYTES)-1:0] cmd_wr_cnt,
    input wire logic [$clog2(NBYTES)-1:0] cmd_rd_cnt,
    input wire logic [8*NBYTES-1:0] cmd_wr_data,
    // status and read data
    output logic busy,
    output logic done,
    output logic nack,
    output logic [8*NBYTES-1:0] rd_data,
    // link clock
    input wire logic link_clk,
    // open-drain serial clock
    output logic scl_o,
    output logic scl_oe,
    // open-drain serial data
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import twm_pkg::*;

    localparam int unsigned CW = $clog2(NBYTES);

    // refuse capacities the byte counters cannot serve
    if (NBYTES < 2 || NBYTES > 16 || (NBYTES & (NBYTES - 1)) != 0) begin
        $error("NBYTES must be a power of two from 2 to 16");
    end
    if (FAST_QTR_CYC < 2 || STD_QTR_CYC >= (1 << QTR_W)) begin
        $error("quarter-bit counts do not fit");
    end

    // command side state
    typedef struct packed {
        logic busy;
        logic done;
        logic nack;
        logic [8*NBYTES-1:0] rd_data;
        logic req_tog;
        logic ack_seen;
        twm_xfer_type xtype;
        logic [ADDR_W-1:0] addr;
        logic fast;
        logic [CW-1:0] wcnt;
        logic [CW-1:0] rcnt;
        logic [8*NBYTES-1:0] wdata;
    } twm_cmd_type;

    // link side state
    typedef struct packed {
        twm_state_type st;
        logic [QTR_W-1:0] cnt;
        logic [QTR_W-1:0] qtr;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] shreg;
        logic [CW-1:0] bidx;
        logic is_rd;
        logic second;
        logic combined;
        logic nack;
        logic [8*NBYTES-1:0] rd_data;
        logic ack_tog;
        logic req_seen;
        logic scl_oe;
        logic sda_oe;
    } twm_link_type;

    twm_cmd_type c_r, c_nxt;
    twm_link_type l_r, l_nxt;
    logic lrst;
    logic req_sync;
    logic ack_sync;
    logic sda_sync;

    // link reset follows the command reset
    twm_sync #(.W(1)) u_rst_sync (
        .clk(link_clk),
        .rst(1'b0),
        .d(rst),
        .q(lrst)
    );

    // command toggle into the link domain
    twm_sync #(.W(1)) u_req_sync (
        .clk(link_clk),
        .rst(lrst),
        .d(c_r.req_tog),
        .q(req_sync)
    );

    // serial data pin into the link domain
    twm_sync #(.W(1)) u_sda_sync (
        .clk(link_clk),
        .rst(lrst),
        .d(sda_i),
        .q(sda_sync)
    );

    // completion toggle back to the command domain
    twm_sync #(.W(1)) u_ack_sync (
        .clk(clk),
        .rst(rst),
        .d(l_r.ack_tog),
        .q(ack_sync)
    );

    // command side: accept, hold fields, collect the result
    always_comb begin
        c_nxt = c_r;
        c_nxt.done = 1'b0;
        if (cmd_start && !c_r.busy) begin
            c_nxt.busy = 1'b1;
            c_nxt.req_tog = ~c_r.req_tog;
            c_nxt.xtype = cmd_type;
            c_nxt.addr = cmd_addr;
            c_nxt.fast = cmd_fast;
            c_nxt.wcnt = cmd_wr_cnt;
            c_nxt.rcnt = cmd_rd_cnt;
            c_nxt.wdata = cmd_wr_data;
        end
        // link results are stable once the toggle arrives
        if (ack_sync != c_r.ack_seen) begin
            c_nxt.ack_seen = ack_sync;
            c_nxt.busy = 1'b0;
            c_nxt.done = 1'b1;
            c_nxt.nack = l_r.nack;
            c_nxt.rd_data = l_r.rd_data;
        end
    end

    // command side register
    always_ff @(posedge clk) begin
        if (rst) begin
            c_r <= '{xtype: TWM_RD, default: '0};
        end else begin
            c_r <= c_nxt;
        end
    end

    // link side bit engine, four quarters per bit
    always_comb begin
        l_nxt = l_r;
        if (l_r.st == TWM_IDLE) begin
            l_nxt.cnt = '0;
            l_nxt.ph = 2'h0;
            l_nxt.scl_oe = 1'b0;
            l_nxt.sda_oe = 1'b0;
            // only a new command starts the bus
            if (req_sync != l_r.req_seen) begin
                l_nxt.req_seen = req_sync;
                l_nxt.st = TWM_START;
                l_nxt.qtr = c_r.fast ? QTR_W'(FAST_QTR_CYC - 1)
                                     : QTR_W'(STD_QTR_CYC - 1);
                l_nxt.cnt = c_r.fast ? QTR_W'(FAST_QTR_CYC - 1)
                                     : QTR_W'(STD_QTR_CYC - 1);
                l_nxt.is_rd = (c_r.xtype == TWM_RD) ||
                              (c_r.xtype == TWM_RD_WR);
                l_nxt.combined = (c_r.xtype == TWM_RD_WR) ||
                                 (c_r.xtype == TWM_WR_RD);
                l_nxt.second = 1'b0;
                l_nxt.nack = 1'b0;
                l_nxt.rd_data = '0;
            end
        end else if (l_r.cnt != '0) begin
            l_nxt.cnt = l_r.cnt - QTR_W'(1);
        end else begin
            l_nxt.cnt = l_r.qtr;
            l_nxt.ph = l_r.ph + 2'h1;
            unique case (l_r.st)
                // start: data falls while clock high
                TWM_START, TWM_RSTART: begin
                    unique case (l_r.ph)
                        2'h0: l_nxt.scl_oe = 1'b0;
                        2'h1: l_nxt.sda_oe = 1'b1;
                        2'h2: l_nxt.scl_oe = 1'b1;
                        2'h3: begin
                            // address goes out again, direction flipped
                            if (l_r.st == TWM_RSTART) begin
                                l_nxt.second = 1'b1;
                                l_nxt.is_rd = ~l_r.is_rd;
                            end
                            l_nxt.shreg = {c_r.addr,
                                (l_r.st == TWM_RSTART) ? ~l_r.is_rd
                                                       : l_r.is_rd};
                            l_nxt.sda_oe = ~c_r.addr[ADDR_W-1];
                            l_nxt.bitn = 4'h0;
                            l_nxt.st = TWM_ADDR;
                        end
                    endcase
                end
                // address and data bytes with acknowledge slot
                TWM_ADDR, TWM_WDATA, TWM_RDATA: begin
                    unique case (l_r.ph)
                        2'h0: l_nxt.scl_oe = 1'b0;
                        2'h1: begin
                            // sample mid-high; no stretch is waited for
                            if (l_r.bitn == ACK_BIT) begin
                                if (l_r.st != TWM_RDATA) begin
                                    l_nxt.nack = sda_sync;
                                end
                            end else if (l_r.st == TWM_RDATA) begin
                                l_nxt.shreg = {l_r.shreg[6:0], sda_sync};
                            end
                        end
                        2'h2: l_nxt.scl_oe = 1'b1;
                        2'h3: begin
                            if (l_r.bitn == ACK_BIT) begin
                                l_nxt = byte_end(l_r, l_nxt);
                            end else begin
                                l_nxt.bitn = l_r.bitn + 4'h1;
                                if (l_r.st == TWM_RDATA) begin
                                    // ack every byte but the last
                                    l_nxt.sda_oe = (l_r.bitn == 4'h7) &&
                                        (l_r.bidx != rd_last(l_r));
                                end else if (l_r.bitn == 4'h7) begin
                                    l_nxt.sda_oe = 1'b0;
                                end else begin
                                    l_nxt.shreg = {l_r.shreg[6:0], 1'b0};
                                    l_nxt.sda_oe = ~l_r.shreg[6];
                                end
                            end
                        end
                    endcase
                end
                // stop: data rises while clock high
                TWM_STOP: begin
                    unique case (l_r.ph)
                        2'h0: l_nxt.scl_oe = 1'b0;
                        2'h1: l_nxt.sda_oe = 1'b0;
                        2'h2: l_nxt.scl_oe = 1'b0;
                        2'h3: begin
                            l_nxt.st = TWM_IDLE;
                            l_nxt.ack_tog = ~l_r.ack_tog;
                        end
                    endcase
                end
                default: l_nxt.st = TWM_IDLE;
            endcase
        end
    end

    // last byte index of the current read leg
    function automatic logic [CW-1:0] rd_last(input twm_link_type s);
        rd_last = c_r.rcnt;
    endfunction

    // last byte index of the current write leg
    function automatic logic [CW-1:0] wr_last(input twm_link_type s);
        wr_last = c_r.wcnt;
    endfunction

    // decide what follows a finished byte slot
    function automatic twm_link_type byte_end(input twm_link_type s,
                                              input twm_link_type n0);
        twm_link_type n;
        logic more;
        logic leg_done;
        n = n0;
        more = 1'b0;
        leg_done = 1'b0;
        n.bitn = 4'h0;
        if (s.st == TWM_ADDR) begin
            n.bidx = '0;
            if (s.nack) begin
                leg_done = 1'b0;
            end else if (s.is_rd) begin
                n.st = TWM_RDATA;
                n.sda_oe = 1'b0;
                more = 1'b1;
            end else begin
                n.st = TWM_WDATA;
                n.shreg = c_r.wdata[8*0 +: 8];
                n.sda_oe = ~c_r.wdata[7];
                more = 1'b1;
            end
        end else if (s.st == TWM_WDATA) begin
            if (!s.nack && s.bidx != wr_last(s)) begin
                n.bidx = s.bidx + CW'(1);
                n.shreg = c_r.wdata[{s.bidx + CW'(1), 3'h0} +: 8];
                n.sda_oe = ~c_r.wdata[{s.bidx + CW'(1), 3'h0} + 7];
                more = 1'b1;
            end else begin
                leg_done = !s.nack;
            end
        end else begin
            n.rd_data[{s.bidx, 3'h0} +: 8] = s.shreg;
            if (s.bidx != rd_last(s)) begin
                n.bidx = s.bidx + CW'(1);
                n.sda_oe = 1'b0;
                more = 1'b1;
            end else begin
                leg_done = 1'b1;
            end
        end
        if (!more) begin
            // second leg follows with no stop between
            if (leg_done && s.combined && !s.second) begin
                n.st = TWM_RSTART;
                n.sda_oe = 1'b0;
            end else begin
                n.st = TWM_STOP;
                n.sda_oe = 1'b1;
            end
        end
        return n;
    endfunction

    // link side register
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            l_r <= '{st: TWM_IDLE, default: '0};
        end else begin
            l_r <= l_nxt;
        end
    end

    // outputs straight from flip-flops; open-drain levels are low
    assign busy = c_r.busy;
    assign done = c_r.done;
    assign nack = c_r.nack;
    assign rd_data = c_r.rd_data;
    assign scl_oe = l_r.scl_oe;
    assign sda_oe = l_r.sda_oe;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

endmodule

// ==== testbench/twm_master_asserts.sv ====
// Purpose: port checks for the two-wire master
// Assumes: sees only twm_master ports
// Notes: bound at the foot of this file
`timescale 1ns/1ns
module twm_master_asserts #(
    parameter int unsigned NBYTES = 4
) (
    // command side
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_start,
    input wire logic busy,
    input wire logic done,
    input wire logic nack,
    input wire logic [8*NBYTES-1:0] rd_data,
    // link side
    input wire logic link_clk,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe
);
    import twm_pkg::*;
    int unsigned bcnt;
    int unsigned hold;
    // busy length, cycles
    always_ff @(posedge clk) begin
        bcnt <= (rst || !busy) ? 0 : bcnt + 1;
    end
    // link cycles since scl last moved
    always_ff @(posedge link_clk) begin
        hold <= (rst || $changed(scl_oe)) ? 0 : hold + 1;
    end
    a_done_pulse: assert property (@(posedge clk) disable iff (rst)
        done |=> !done) else $error("done longer than one cycle");
    a_done_busy: assert property (@(posedge clk) disable iff (rst)
        done |-> !busy && $past(busy)) else $error("done off busy");
    a_start_busy: assert property (@(posedge clk) disable iff (rst)
        cmd_start && !busy |=> busy) else $error("start not taken");
    a_idle_bus: assert property (@(posedge clk) disable iff (rst)
        !busy |-> !scl_oe && !sda_oe) else $error("bus driven idle");
    a_busy_bound: assert property (@(posedge clk) disable iff (rst)
        bcnt < 12000) else $error("transfer never ends");
    a_nack_hold: assert property (@(posedge clk) disable iff (rst)
        $changed(nack) |-> done) else $error("nack moved off done");
    a_od_low: assert property (@(posedge link_clk) disable iff (rst)
        !scl_o && !sda_o) else $error("pin value not low");
    a_scl_quarter: assert property (@(posedge link_clk) disable iff (rst)
        $changed(scl_oe) |-> hold >= FAST_QTR_CYC - 1)
        else $error("scl phase too short");
    // main scenarios
    c_nack: cover property (@(posedge clk) done && nack);
    c_ok: cover property (@(posedge clk) done && !nack);
    c_busy_start: cover property (@(posedge clk) busy && cmd_start);
endmodule
bind twm_master twm_master_asserts #(.NBYTES(NBYTES)) twm_chk_i (
    .clk(clk), .rst(rst), .cmd_start(cmd_start), .busy(busy),
    .done(done), .nack(nack), .rd_data(rd_data), .link_clk(link_clk),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));

// ==== testbench/twm_slave_model.sv ====
// Purpose: behavioural two-wire slave on the bus side
// Assumes: scl and sda are resolved open-drain levels
// Notes: reads give 8'ha0 plus index; writes land in wbuf
`timescale 1ns/1ns
module twm_slave_model #(
    parameter logic [6:0] DEV = 7'h50
) (
    // bus levels
    input wire logic scl,
    input wire logic sda,
    // high pulls sda low
    output logic pull
);
    logic [7:0] sh, rb;
    logic [7:0] wbuf [0:7];
    int bn = 0, wn = 0, rn = 0;
    logic act = 0, adr = 0, rd = 0, quit = 0;
    initial pull = 0;
    // start or repeated start opens a frame
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1; adr = 1; bn = 0; quit = 0; pull = 0;
    end
    // stop releases the line
    always @(posedge sda) if (scl === 1'b1) begin
        act = 0; pull = 0;
    end
    // sample on scl rise; master nack ends a read
    always @(posedge scl) if (act) begin
        sh = {sh[6:0], sda};
        bn = bn + 1;
        if (bn == 9 && rd && !adr) quit = sda;
    end
    // drive only while scl low, never stretch it
    always @(negedge scl) if (act) begin
        if (bn == 8 && adr) begin
            rd = sh[0];
            act = (sh[7:1] == DEV);
            pull = act;
            rn = 0;
            if (!rd && act) wn = 0;
        end else if (bn == 8) begin
            if (!rd) wbuf[wn] = sh;
            if (!rd) wn++;
            pull = !rd;
        end else if (bn == 9) begin
            bn = 0; adr = 0;
            rb = 8'ha0 + rn[7:0];
            rn++;
            pull = rd && !quit && !rb[7];
        end else begin
            pull = rd && !adr && !quit && !rb[7-bn];
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the two-wire master
// Assumes: slave model at 7'h50 on an open-drain bus
// Notes: bus monitors count starts and stops and keep the shortest scl period
`timescale 1ns/1ns
module testbench;
    import twm_pkg::*;
    logic clk = 0, link_clk = 0, rst = 1, cmd_start = 0, cmd_fast = 1;
    twm_xfer_type cmd_type = TWM_RD;
    logic [6:0] cmd_addr = 7'h50;
    logic [1:0] cmd_wr_cnt = 0, cmd_rd_cnt = 0;
    logic [31:0] cmd_wr_data = 0, rd_data;
    logic busy, done, nack, scl_o, scl_oe, sda_o, sda_oe, pull;
    wire scl = !scl_oe;
    wire sda = !(sda_oe || pull);
    int n_mismatch = 0, samples_checked = 0, n_start = 0, n_stop = 0;
    realtime t_rise = 0, min_per = 1e9;
    // clocks, link offset in phase
    always #50 clk = ~clk;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    twm_master #(.NBYTES(4)) twm_master_i (.clk(clk), .rst(rst),
        .cmd_start(cmd_start), .cmd_type(cmd_type), .cmd_addr(cmd_addr),
        .cmd_fast(cmd_fast), .cmd_wr_cnt(cmd_wr_cnt),
        .cmd_rd_cnt(cmd_rd_cnt), .cmd_wr_data(cmd_wr_data), .busy(busy),
        .done(done), .nack(nack), .rd_data(rd_data), .link_clk(link_clk),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe));
    twm_slave_model #(.DEV(7'h50)) twm_slave_model_i (.scl(scl),
        .sda(sda), .pull(pull));
    // bus monitors
    always @(negedge sda) if (scl === 1'b1) n_start++;
    always @(posedge sda) if (scl === 1'b1) n_stop++;
    always @(posedge scl) begin
        if ($realtime - t_rise < min_per) min_per = $realtime - t_rise;
        t_rise = $realtime;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one command, bounded wait for done
    task automatic run(input twm_xfer_type t, input logic [6:0] a,
        input logic [1:0] w, input logic [1:0] r, input logic [31:0] d,
        input logic f);
        int k;
        n_start = 0;
        n_stop = 0;
        min_per = 1e9;
        @(posedge clk);
        cmd_type <= t;
        cmd_addr <= a;
        cmd_wr_cnt <= w;
        cmd_rd_cnt <= r;
        cmd_wr_data <= d;
        cmd_fast <= f;
        cmd_start <= 1;
        @(posedge clk);
        cmd_start <= 0;
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk({31'h0, k < 20000}, 32'h1);
        chk({31'h0, busy}, 32'h0);
    endtask
    task automatic t_idle;
        repeat (20) @(posedge clk);
        chk({n_start[7:0], 22'h0, scl_oe, sda_oe}, 32'h0);
        $display("end idle");
    endtask
    task automatic t_write;
        run(TWM_WR, 7'h50, 2'h3, 2'h0, 32'h8c5a3e01, 1);
        chk({twm_slave_model_i.wbuf[3], twm_slave_model_i.wbuf[2],
            twm_slave_model_i.wbuf[1], twm_slave_model_i.wbuf[0]},
            32'h8c5a3e01);
        chk({n_start[7:0], n_stop[7:0], 15'h0, nack}, 32'h01010000);
        chk({31'h0, min_per >= 2500 && min_per < 5000}, 32'h1);
        chk(rd_data, 32'h0);
        $display("end write");
    endtask
    task automatic t_read;
        run(TWM_RD, 7'h50, 2'h0, 2'h2, 32'h0, 0);
        chk(rd_data, 32'h00a2a1a0);
        chk({31'h0, min_per >= 10000}, 32'h1);
        chk({31'h0, nack}, 32'h0);
        $display("end read");
    endtask
    task automatic t_wr_rd;
        run(TWM_WR_RD, 7'h50, 2'h0, 2'h1, 32'h77, 1);
        chk(rd_data, 32'h0000a1a0);
        chk({twm_slave_model_i.wbuf[0], n_start[7:0], n_stop[7:0], 8'h0},
            32'h77020100);
        $display("end write-read");
    endtask
    task automatic t_rd_wr;
        run(TWM_RD_WR, 7'h50, 2'h1, 2'h0, 32'h3c5d, 1);
        chk(rd_data, 32'h000000a0);
        chk({twm_slave_model_i.wbuf[1], twm_slave_model_i.wbuf[0],
            n_start[7:0], n_stop[7:0]}, 32'h3c5d0201);
        $display("end read-write");
    endtask
    task automatic t_nack;
        run(TWM_WR, 7'h51, 2'h1, 2'h0, 32'h1234, 1);
        chk({31'h0, nack}, 32'h1);
        $display("end refused address");
    endtask
    // watchdog
    initial begin
        #5_000_000;
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        t_idle;
        t_write;
        t_read;
        t_wr_rd;
        t_rd_wr;
        t_nack;
        final_report;
    end
endmodule
